// ---- common/wdg_consts.svh ----
// constants for the watchdog register frames
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets inside a frame
// ------------------------------------------------------------
`define WDG_OFF_REFRESH  12'h000
`define WDG_OFF_CTRL     12'h000
`define WDG_OFF_OFFSET   12'h008
`define WDG_OFF_CMP_LO   12'h010
`define WDG_OFF_CMP_HI   12'h014
`define WDG_OFF_IDENT    12'hFCC
// ------------------------------------------------------------
// control/status fields
// ------------------------------------------------------------
`define WDG_CS_ENABLE    0
`define WDG_CS_FIRST     1
`define WDG_CS_SECOND    2
// ------------------------------------------------------------
// identification fields
// ------------------------------------------------------------
`define WDG_ID_PROD_HI   31
`define WDG_ID_PROD_LO   20
`define WDG_ID_ARCH_HI   19
`define WDG_ID_ARCH_LO   16
`define WDG_ID_REV_HI    15
`define WDG_ID_REV_LO    12
`define WDG_ID_CONT_HI   11
`define WDG_ID_CONT_LO   8
`define WDG_ID_ZERO      7
`define WDG_ID_CODE_HI   6
`define WDG_ID_CODE_LO   0
`define WDG_ARCH_VER     4'h0
// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define WDG_WORD_ZERO    32'h0000_0000
`define WDG_CMP_RESET    64'h0000_0000_0000_0000
`define WDG_BE_FULL      4'hF
`endif

// ---- common/wdg_pkg.sv ----
// types shared by the watchdog register frames
package wdg_pkg;
  typedef logic [31:0] wdg_word_t;
  typedef logic [63:0] wdg_count_t;
  typedef logic [11:0] wdg_addr_t;
  typedef logic [3:0]  wdg_be_t;
  typedef enum logic {
    WDG_AVS_IDLE = 1'b0,
    WDG_AVS_RESP = 1'b1
  } wdg_avs_state_t;
endpackage

// ---- dv/tb_wdg_top.sv ----
// self-checking bench for the watchdog register frames
`timescale 1ns/1ps
module tb_wdg_top;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic                mclk       = 1'b0;
  logic                resetn     = 1'b0;
  logic                warmResetn = 1'b1;
  logic                clkEn      = 1'b1;
  wdg_pkg::wdg_count_t sysCount   = 64'h0;
  wdg_pkg::wdg_addr_t  busAddr    = 12'h000;
  wdg_pkg::wdg_word_t  busData    = 32'h0;
  wdg_pkg::wdg_be_t    busBe      = 4'hF;
  logic                busCf      = 1'b0;
  logic                busRd      = 1'b0;
  logic                busWr      = 1'b0;
  wdg_pkg::wdg_word_t  rfReaddata;
  wdg_pkg::wdg_word_t  cfReaddata;
  wdg_pkg::wdg_word_t  rdq;
  logic                rfWaitrequest;
  logic                cfWaitrequest;
  logic                fst;
  logic                snd;
  int                  fail_count = 0;
  int                  num_checks = 0;
  wdg_pkg::wdg_addr_t  rsv [5] = '{12'h004, 12'h00C, 12'h018, 12'hFD0, 12'hFFC};
  // id values are arbitrary
  localparam wdg_pkg::wdg_word_t ID = {12'hA5C, 4'h0, 4'h3, 4'h9, 1'b0, 7'h2B};
  always #5 mclk = ~mclk;
  wdg_top #(.PRODUCT_ID(12'hA5C), .REVISION(4'h3), .JEP_CONT(4'h9), .JEP_CODE(7'h2B)) u_dut (
    .mclk(mclk), .resetn(resetn), .warmResetn(warmResetn), .clkEn(clkEn), .sysCount(sysCount),
    .rfAddress(busAddr), .rfRead(busRd && !busCf), .rfWrite(busWr && !busCf),
    .rfWritedata(busData), .rfByteenable(busBe), .rfReaddata(rfReaddata),
    .rfWaitrequest(rfWaitrequest),
    .cfAddress(busAddr), .cfRead(busRd && busCf), .cfWrite(busWr && busCf),
    .cfWritedata(busData), .cfByteenable(busBe), .cfReaddata(cfReaddata),
    .cfWaitrequest(cfWaitrequest),
    .firstStageTimeoutSignal(fst), .secondStageTimeoutSignal(snd)
  );
  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic acc(input logic cf, input logic we, input wdg_pkg::wdg_addr_t a,
                     input wdg_pkg::wdg_word_t d, input wdg_pkg::wdg_be_t be);
    int n;
    n = 0;
    busCf <= cf;
    busAddr <= a;
    busData <= d;
    busBe <= be;
    busWr <= we;
    busRd <= !we;
    do begin
      @(posedge mclk);
      n++;
    end while ((cf ? cfWaitrequest : rfWaitrequest) !== 1'b0 && n < 64);
    if ((cf ? cfWaitrequest : rfWaitrequest) !== 1'b0) begin
      $display("[FAIL] %0t: no bus answer", $time);
      fail_count++;
    end
    rdq = cf ? cfReaddata : rfReaddata;
    busRd <= 1'b0;
    busWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input wdg_pkg::wdg_word_t got, input wdg_pkg::wdg_word_t exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic rd(input logic cf, input wdg_pkg::wdg_addr_t a, input wdg_pkg::wdg_word_t e);
    acc(cf, 1'b0, a, 32'h0, 4'hF);
    chk(rdq, e);
  endtask
  task automatic wr(input logic cf, input wdg_pkg::wdg_addr_t a, input wdg_pkg::wdg_word_t d);
    acc(cf, 1'b1, a, d, 4'hF);
  endtask
  task automatic sigs(input logic [1:0] e);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({30'h0, snd, fst}, {30'h0, e});
    @(posedge mclk);
  endtask
  task automatic results();
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(1'b1, 12'h000, 32'h0);
    rd(1'b1, 12'h008, 32'h0);
    rd(1'b1, 12'h014, 32'h0);
    rd(1'b0, 12'hFCC, ID);
    fork
      rd(1'b1, 12'hFCC, ID);
      begin
        @(posedge mclk);
        clkEn <= 1'b0;
        repeat (3) @(posedge mclk);
        clkEn <= 1'b1;
      end
    join
    wr(1'b1, 12'h008, 32'hFFFF_FFFF);
    acc(1'b1, 1'b1, 12'h008, 32'h0, 4'h3);
    rd(1'b1, 12'h008, 32'hFFFF_FFFF);
    wr(1'b1, 12'h010, 32'h89AB_CDEF);
    wr(1'b1, 12'h014, 32'h0123_4567);
    rd(1'b1, 12'h010, 32'h89AB_CDEF);
    rd(1'b1, 12'h014, 32'h0123_4567);
    wr(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd(1'b1, 12'h000, 32'h1);
    sysCount <= 64'd100;
    wr(1'b1, 12'h008, 32'd10);
    wr(1'b0, 12'h000, 32'hDEAD_0000);
    rd(1'b1, 12'h010, 32'd110);
    rd(1'b1, 12'h014, 32'h0);
    sysCount <= 64'd110;
    sigs(2'b00);
    sysCount <= 64'd111;
    sigs(2'b01);
    rd(1'b1, 12'h010, 32'd121);
    rd(1'b0, 12'h000, 32'h0);
    sigs(2'b01);
    sysCount <= 64'd122;
    sigs(2'b11);
    rd(1'b1, 12'h000, 32'h7);
    wr(1'b1, 12'h000, 32'h7);
    sigs(2'b00);
    sysCount <= 64'd133;
    sigs(2'b01);
    wr(1'b0, 12'h004, 32'h1);
    wr(1'b1, 12'h004, 32'h1);
    sigs(2'b01);
    foreach (rsv[i]) begin
      rd(1'b1, rsv[i], 32'h0);
      rd(1'b0, rsv[i], 32'h0);
    end
    rd(1'b0, 12'h008, 32'h0);
    warmResetn <= 1'b0;
    repeat (2) @(posedge mclk);
    warmResetn <= 1'b1;
    @(posedge mclk);
    rd(1'b1, 12'h000, 32'h3);
    wr(1'b1, 12'h000, 32'h0);
    sysCount <= 64'd500;
    sigs(2'b00);
    rd(1'b1, 12'h000, 32'h0);
    wr(1'b1, 12'h000, 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(1'b1, 12'h000, 32'h0);
    results();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    $display("[FAIL] %0t: run timed out", $time);
    fail_count++;
    results();
  end
endmodule // tb_wdg_top

// ---- dv/wdg_top_monitor.sv ----
// concurrent checks on the ports of the watchdog register frames
`timescale 1ns/1ps
module wdg_top_monitor (
  // clock and reset
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic               clkEn,
  // refresh frame
  input wire wdg_pkg::wdg_addr_t rfAddress,
  input wire logic               rfRead,
  input wire logic               rfWrite,
  input wire wdg_pkg::wdg_be_t   rfByteenable,
  input wire wdg_pkg::wdg_word_t rfReaddata,
  input wire logic               rfWaitrequest,
  // control frame
  input wire wdg_pkg::wdg_addr_t cfAddress,
  input wire logic               cfRead,
  input wire logic               cfWrite,
  input wire wdg_pkg::wdg_be_t   cfByteenable,
  input wire wdg_pkg::wdg_word_t cfReaddata,
  input wire logic               cfWaitrequest,
  // timeout signals
  input wire logic               firstStageTimeoutSignal,
  input wire logic               secondStageTimeoutSignal
);
  logic fst;
  logic snd;
  assign fst = firstStageTimeoutSignal;
  assign snd = secondStageTimeoutSignal;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------
  cf_answer_a: assert property (($rose(cfRead) || $rose(cfWrite)) && clkEn ##1 clkEn
    |-> !cfWaitrequest) else $error("control frame answer late");
  rf_answer_a: assert property (($rose(rfRead) || $rose(rfWrite)) && clkEn ##1 clkEn
    |-> !rfWaitrequest) else $error("refresh frame answer late");
  rf_read_zero_a: assert property (rfRead && !rfWaitrequest && rfAddress[11:2] == 10'h000
    |-> rfReaddata == 32'h0000_0000) else $error("refresh read not zero");
  cs_read_a: assert property (cfRead && !cfWaitrequest && cfAddress[11:2] == 10'h000
    |-> cfReaddata[31:3] == 29'h0 && cfReaddata[2:1] == {$past(snd), $past(fst)})
    else $error("control read wrong");
  id_read_a: assert property ((cfRead && !cfWaitrequest && cfAddress[11:2] == 10'h3F3)
    |-> cfReaddata[19:16] == 4'h0 && !cfReaddata[7]) else $error("id fields wrong");
  rsvd_read_a: assert property (cfRead && !cfWaitrequest && (cfAddress[11:2] == 10'h001
    || (cfAddress[11:2] > 10'h005 && cfAddress[11:2] < 10'h3F3)) |-> cfReaddata == 32'h0)
    else $error("reserved read not zero");
  // ------------------------------------------------------------
  // timeout signals
  // ------------------------------------------------------------
  refresh_clear_a: assert property ((rfWrite && !rfWaitrequest && rfByteenable == 4'hF
    && rfAddress[11:2] == 10'h000) || (cfWrite && !cfWaitrequest && cfByteenable == 4'hF
    && (cfAddress[11:2] == 10'h000 || cfAddress[11:2] == 10'h002)) |=> !fst && !snd)
    else $error("refresh did not clear signals");
  rf_read_keep_a: assert property (rfRead && !rfWaitrequest && fst && !cfWrite |=> fst)
    else $error("refresh read changed state");
  stage_order_a: assert property ($rose(snd) |-> fst)
    else $error("second stage without first");
  first_rise_a: assert property ($rose(fst) |-> !snd)
    else $error("first stage rose late");
endmodule // wdg_top_monitor

bind wdg_top wdg_top_monitor u_mon (
  .mclk(mclk), .resetn(resetn), .clkEn(clkEn),
  .rfAddress(rfAddress), .rfRead(rfRead), .rfWrite(rfWrite), .rfByteenable(rfByteenable),
  .rfReaddata(rfReaddata), .rfWaitrequest(rfWaitrequest),
  .cfAddress(cfAddress), .cfRead(cfRead), .cfWrite(cfWrite), .cfByteenable(cfByteenable),
  .cfReaddata(cfReaddata), .cfWaitrequest(cfWaitrequest),
  .firstStageTimeoutSignal(firstStageTimeoutSignal),
  .secondStageTimeoutSignal(secondStageTimeoutSignal)
);

// ---- hdl/wdg_avs.sv ----
// avalon-mm slave handshake for one watchdog register frame
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_avs (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              warmResetn,
  input  wire logic              clkEn,
  // avalon-mm slave
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire wdg_pkg::wdg_be_t  avsByteenable,
  output logic                   avsWaitrequest,
  output wdg_pkg::wdg_word_t     avsReaddata,
  // user side
  input  wire wdg_pkg::wdg_word_t rdWord,
  output logic                   wrStrobe
);
  // ------------------------------------------------------------
  // handshake state
  // ------------------------------------------------------------
  wdg_pkg::wdg_avs_state_t state_q;
  wdg_pkg::wdg_avs_state_t state_d;
  wdg_pkg::wdg_word_t      readdata_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wdg_pkg::WDG_AVS_IDLE: begin
        if (avsRead || avsWrite) begin
          state_d = wdg_pkg::WDG_AVS_RESP;
        end
      end
      wdg_pkg::WDG_AVS_RESP: begin
        state_d = wdg_pkg::WDG_AVS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= wdg_pkg::WDG_AVS_IDLE;
    end else if (!warmResetn) begin
      state_q <= wdg_pkg::WDG_AVS_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // read data captured one cycle before release
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      readdata_q <= `WDG_WORD_ZERO;
    end else if (clkEn && state_q == wdg_pkg::WDG_AVS_IDLE && avsRead) begin
      readdata_q <= rdWord;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avsWaitrequest = !(state_q == wdg_pkg::WDG_AVS_RESP && clkEn);
  assign avsReaddata    = readdata_q;
  // only full 32-bit writes act
  assign wrStrobe = state_q == wdg_pkg::WDG_AVS_RESP && clkEn && avsWrite
                    && avsByteenable == `WDG_BE_FULL;
endmodule // wdg_avs

// ---- hdl/wdg_top.sv ----
// two-frame watchdog: refresh frame, control frame and timeout logic
// Notes on behaviour
// - registers are 32 bits, full-word access
// - separate refresh frame and control frame
// - register contents are little-endian
// - any refresh write restarts the watch period
// - refresh register reads zero, no effect
// - identification word at same offset, both frames
// - offset register is read/write 32-bit
// - compare value as low/high read/write words
// - control/status upper bits read zero
// - bits 2 and 1 show stage signals
// - writes to status bits change nothing
// - bit 0 enables, reads enable state
// - cold reset clears the enable bit
// - id: product top, revision bits 15:12
// - id bits 19:16 architecture version zero
// - id low twelve bits implementer code
// - refresh, offset, control writes refresh
// - refresh loads count plus offset
// - timeout raises first, then second stage
// - disabled watchdog holds signals low
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_top #(
  // identification values, arbitrary
  parameter logic [11:0] PRODUCT_ID = 12'h001,
  parameter logic [3:0]  REVISION   = 4'h0,
  parameter logic [3:0]  JEP_CONT   = 4'h0,
  parameter logic [6:0]  JEP_CODE   = 7'h01
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               warmResetn,
  input  wire logic               clkEn,
  // system counter timebase
  input  wire wdg_pkg::wdg_count_t sysCount,
  // refresh frame avalon-mm slave
  input  wire wdg_pkg::wdg_addr_t rfAddress,
  input  wire logic               rfRead,
  input  wire logic               rfWrite,
  input  wire wdg_pkg::wdg_word_t rfWritedata,
  input  wire wdg_pkg::wdg_be_t   rfByteenable,
  output wdg_pkg::wdg_word_t      rfReaddata,
  output logic                    rfWaitrequest,
  // control frame avalon-mm slave
  input  wire wdg_pkg::wdg_addr_t cfAddress,
  input  wire logic               cfRead,
  input  wire logic               cfWrite,
  input  wire wdg_pkg::wdg_word_t cfWritedata,
  input  wire wdg_pkg::wdg_be_t   cfByteenable,
  output wdg_pkg::wdg_word_t      cfReaddata,
  output logic                    cfWaitrequest,
  // timeout signals
  output logic                    firstStageTimeoutSignal,
  output logic                    secondStageTimeoutSignal
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // word-aligned offset match; low two bits select bytes only
  function automatic logic hitOffset(
    input wdg_pkg::wdg_addr_t addr,
    input wdg_pkg::wdg_addr_t off
  );
    hitOffset = addr[11:2] == off[11:2];
  endfunction

  // identification word, same in both frames
  function automatic wdg_pkg::wdg_word_t identWord();
    wdg_pkg::wdg_word_t w;
    w = `WDG_WORD_ZERO;
    w[`WDG_ID_PROD_HI:`WDG_ID_PROD_LO] = PRODUCT_ID;
    w[`WDG_ID_ARCH_HI:`WDG_ID_ARCH_LO] = `WDG_ARCH_VER;
    w[`WDG_ID_REV_HI:`WDG_ID_REV_LO]   = REVISION;
    w[`WDG_ID_CONT_HI:`WDG_ID_CONT_LO] = JEP_CONT;
    w[`WDG_ID_ZERO]                    = 1'b0;
    w[`WDG_ID_CODE_HI:`WDG_ID_CODE_LO] = JEP_CODE;
    identWord = w;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic               enable_q;
  logic               first_q;
  logic               second_q;
  wdg_pkg::wdg_word_t offset_q;
  wdg_pkg::wdg_count_t compare_q;

  // ------------------------------------------------------------
  // bus strobes
  // ------------------------------------------------------------
  logic               rfWrStrobe;
  logic               cfWrStrobe;
  wdg_pkg::wdg_word_t rfRdWord;
  wdg_pkg::wdg_word_t cfRdWord;

  // ------------------------------------------------------------
  // refresh frame slave
  // ------------------------------------------------------------
  wdg_avs u_rf_avs (
    .mclk           (mclk),
    .resetn         (resetn),
    .warmResetn     (warmResetn),
    .clkEn          (clkEn),
    .avsRead        (rfRead),
    .avsWrite       (rfWrite),
    .avsByteenable  (rfByteenable),
    .avsWaitrequest (rfWaitrequest),
    .avsReaddata    (rfReaddata),
    .rdWord         (rfRdWord),
    .wrStrobe       (rfWrStrobe)
  );

  // ------------------------------------------------------------
  // control frame slave
  // ------------------------------------------------------------
  wdg_avs u_cf_avs (
    .mclk           (mclk),
    .resetn         (resetn),
    .warmResetn     (warmResetn),
    .clkEn          (clkEn),
    .avsRead        (cfRead),
    .avsWrite       (cfWrite),
    .avsByteenable  (cfByteenable),
    .avsWaitrequest (cfWaitrequest),
    .avsReaddata    (cfReaddata),
    .rdWord         (cfRdWord),
    .wrStrobe       (cfWrStrobe)
  );

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic wrRefresh;
  logic wrCtrl;
  logic wrOffset;
  logic wrCmpLo;
  logic wrCmpHi;

  // any data value refreshes
  assign wrRefresh = rfWrStrobe && hitOffset(rfAddress, `WDG_OFF_REFRESH);
  assign wrCtrl    = cfWrStrobe && hitOffset(cfAddress, `WDG_OFF_CTRL);
  assign wrOffset  = cfWrStrobe && hitOffset(cfAddress, `WDG_OFF_OFFSET);
  assign wrCmpLo   = cfWrStrobe && hitOffset(cfAddress, `WDG_OFF_CMP_LO);
  assign wrCmpHi   = cfWrStrobe && hitOffset(cfAddress, `WDG_OFF_CMP_HI);
  // other offsets produce no strobe at all

  // ------------------------------------------------------------
  // refresh and timeout events
  // ------------------------------------------------------------
  logic                explicitRefresh;
  logic                timeoutHit;
  logic                loadCompare;
  wdg_pkg::wdg_count_t reloadValue;

  assign explicitRefresh = wrRefresh || wrOffset || wrCtrl;
  assign timeoutHit      = sysCount > compare_q;
  // sum stays 64 bits, wrap is intended
  assign reloadValue = sysCount + {32'h0000_0000, offset_q};
  // second stage keeps the compare value as its timestamp
  assign loadCompare = explicitRefresh || (timeoutHit && !first_q);

  // ------------------------------------------------------------
  // enable bit
  // ------------------------------------------------------------
  // of the two resets only the cold one clears it; warm reset leaves it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
    end else if (clkEn && wrCtrl) begin
      enable_q <= cfWritedata[`WDG_CS_ENABLE];
    end
  end

  // ------------------------------------------------------------
  // offset register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      offset_q <= `WDG_WORD_ZERO;
    end else if (clkEn && wrOffset) begin
      offset_q <= cfWritedata;
    end
  end

  // ------------------------------------------------------------
  // compare value
  // ------------------------------------------------------------
  // a direct write takes priority over any reload
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      compare_q <= `WDG_CMP_RESET;
    end else if (clkEn) begin
      if (wrCmpLo) begin
        compare_q[31:0] <= cfWritedata;
      end else if (wrCmpHi) begin
        compare_q[63:32] <= cfWritedata;
      end else if (loadCompare) begin
        compare_q <= reloadValue;
      end
    end
  end

  // ------------------------------------------------------------
  // first stage timeout signal
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b0;
    end else if (clkEn) begin
      if (!enable_q) begin
        first_q <= 1'b0;
      end else if (explicitRefresh) begin
        first_q <= 1'b0;
      end else if (timeoutHit) begin
        first_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // second stage timeout signal
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      second_q <= 1'b0;
    end else if (clkEn) begin
      if (!enable_q) begin
        second_q <= 1'b0;
      end else if (explicitRefresh) begin
        second_q <= 1'b0;
      end else if (timeoutHit && first_q) begin
        second_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // refresh frame read decode
  // ------------------------------------------------------------
  always_comb begin
    rfRdWord = `WDG_WORD_ZERO;
    if (hitOffset(rfAddress, `WDG_OFF_REFRESH)) begin
      rfRdWord = `WDG_WORD_ZERO;
    end else if (hitOffset(rfAddress, `WDG_OFF_IDENT)) begin
      rfRdWord = identWord();
    end
  end

  // ------------------------------------------------------------
  // control frame read decode
  // ------------------------------------------------------------
  // bit n of a word sits on byte lane n/8
  always_comb begin
    cfRdWord = `WDG_WORD_ZERO;
    if (hitOffset(cfAddress, `WDG_OFF_CTRL)) begin
      // upper bits stay zero
      cfRdWord[`WDG_CS_ENABLE] = enable_q;
      cfRdWord[`WDG_CS_FIRST]  = first_q;
      cfRdWord[`WDG_CS_SECOND] = second_q;
    end else if (hitOffset(cfAddress, `WDG_OFF_OFFSET)) begin
      cfRdWord = offset_q;
    end else if (hitOffset(cfAddress, `WDG_OFF_CMP_LO)) begin
      cfRdWord = compare_q[31:0];
    end else if (hitOffset(cfAddress, `WDG_OFF_CMP_HI)) begin
      cfRdWord = compare_q[63:32];
    end else if (hitOffset(cfAddress, `WDG_OFF_IDENT)) begin
      cfRdWord = identWord();
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // status bits are read-only views; writes reach only bit 0
  assign firstStageTimeoutSignal  = first_q;
  assign secondStageTimeoutSignal = second_q;

endmodule // wdg_top
